// File: verif/tb_timer_ch34_mode_config.sv
// Self-checking bench for the channel 3/4 mode block
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_errors++; \
	$display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb_timer_ch34_mode_config
	import timer_ch34_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] MODE = MODE_CFG_TIMER1_OFFSET;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000, counter_value = 16'h00FF;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic        pready, pslverr, rerr, count_down = 1'b0, update_event = 1'b0, trigger_edge = 1'b0;
	logic        ch3_polarity = 1'b0, ch4_polarity = 1'b0, ch3_channel_enable = 1'b0, ch4_channel_enable = 1'b0;
	logic        timer_input_three, timer_input_four, internal_trigger_input, busy, start = 1'b0;
	logic        ch3_reference_level, ch4_reference_level, ch3_compare_output, ch4_compare_output;
	logic        ch3_capture_event, ch4_capture_event;
	logic [1:0]  pick = 2'd0;
	logic [3:0]  npulse = 4'h0;
	logic [6:0]  half = 7'h01;
	int          n_errors = 0, comparisons = 0, n3 = 0, n4 = 0;

	timer_ch34_mode_config timer_ch34_mode_config_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .counter_value, .count_down, .update_event, .trigger_edge,
		.timer_input_three, .timer_input_four, .internal_trigger_input, .ch3_polarity, .ch4_polarity,
		.ch3_channel_enable, .ch4_channel_enable, .ch3_reference_level, .ch4_reference_level,
		.ch3_compare_output, .ch4_compare_output, .ch3_capture_event, .ch4_capture_event);
	timer_pin_model timer_pin_model_inst (.pclk, .presetn, .start, .pick, .npulse, .half,
		.timer_input_three, .timer_input_four, .internal_trigger_input, .busy);

	always #2.5 pclk = ~pclk;

	always @(posedge pclk)
	begin
		if (ch3_capture_event === 1'b1)
			n3++;
		if (ch4_capture_event === 1'b1)
			n4++;
	end

	task automatic conclude;
		if (n_errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No local limit: only the watchdog may end a wait for the slave
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	task automatic hit(input logic [15:0] v);
		@(posedge pclk);
		counter_value <= 16'h0000;
		@(posedge pclk);
		counter_value <= v;
		step(3);
	endtask

	task automatic t_regs;
		apb(1'b0, MODE, 32'h0);
		`CHK("mode reset", 32'h0000_0000, rdat)
		apb(1'b1, MODE, 32'hFFFF_1234);
		apb(1'b0, MODE, 32'h0);
		`CHK("mode", 32'h0000_1234, rdat)
		apb(1'b0, STATUS_OFFSET, 32'h0);
		`CHK("input flags", 2'b10, rdat[5:4])
		apb(1'b0, MODE_CFG_TIMER2_OFFSET, 32'h0);
		`CHK("unmapped error", 1'b1, rerr)
		apb(1'b1, MODE, 32'h0);
	endtask

	task automatic t_force;
		@(posedge pclk);
		ch3_polarity <= 1'b1;
		ch4_polarity <= 1'b1;
		apb(1'b1, MODE, 32'h0000_5000);
		step(2);
		`CHK("forced high", 1'b1, ch4_reference_level)
		`CHK("inverted out", 1'b0, ch4_compare_output)
		`CHK("ch3 out", 1'b1, ch3_compare_output)
		apb(1'b1, MODE, 32'h0000_4000);
		step(2);
		`CHK("forced low", 1'b0, ch4_reference_level)
		@(posedge pclk);
		ch3_polarity <= 1'b0;
		ch4_polarity <= 1'b0;
	endtask

	task automatic t_match;
		logic [2:0] m;
		apb(1'b1, CH4_COMPARE_OFFSET, 32'h0000_0010);
		for (int i = 1; i < 5; i++)
		begin
			m = i == 4 ? 3'h0 : 3'(i);
			apb(1'b1, MODE, {17'h0, m, 12'h000});
			hit(16'h0010);
			`CHK("match ref", 4'b1101 >> (i - 1) & 4'h1, {3'h0, ch4_reference_level})
		end
	endtask

	task automatic t_pwm;
		logic [15:0] c [4];
		c = '{16'h0005, 16'h0020, 16'h0020, 16'h0008};
		for (int i = 0; i < 8; i++)
		begin
			if (i % 4 == 0)
				apb(1'b1, MODE, 32'h0);
			apb(1'b1, MODE, i < 4 ? 32'h0000_6800 : 32'h0000_7800);
			@(posedge pclk);
			count_down    <= i[1];
			counter_value <= c[i % 4];
			step(2);
			`CHK("pwm ref", 4'b1001 >> (i % 4) & 4'h1 ^ 4'(i / 4), {3'h0, ch4_reference_level})
		end
	endtask

	task automatic t_fast;
		logic [31:0] m [3];
		m = '{32'h0000_6C00, 32'h0000_6800, 32'h0000_0400};
		for (int i = 0; i < 3; i++)
		begin
			apb(1'b1, MODE, 32'h0000_4000);
			apb(1'b1, MODE, 32'h0);
			apb(1'b1, MODE, m[i]);
			@(posedge pclk);
			count_down    <= 1'b0;
			counter_value <= 16'h0020;
			step(3);
			@(posedge pclk);
			trigger_edge <= 1'b1;
			@(posedge pclk);
			trigger_edge <= 1'b0;
			step(1);
			`CHK("fast early", 1'b0, ch4_reference_level)
			step(1);
			`CHK("fast", i == 0, ch4_reference_level)
			step(3);
			`CHK("fast late", i == 0, ch4_reference_level)
		end
	endtask

	task automatic t_buffer;
		apb(1'b1, MODE, 32'h0000_4000);
		apb(1'b1, MODE, 32'h0000_1800);
		apb(1'b1, CH4_COMPARE_OFFSET, 32'h0000_0040);
		apb(1'b0, CH4_COMPARE_OFFSET, 32'h0);
		`CHK("buffer read", 32'h0000_0040, rdat)
		hit(16'h0040);
		`CHK("before update", 1'b0, ch4_reference_level)
		@(posedge pclk);
		update_event <= 1'b1;
		@(posedge pclk);
		update_event <= 1'b0;
		hit(16'h0040);
		`CHK("after update", 1'b1, ch4_reference_level)
	endtask

	task automatic cap(input logic ch, input logic [7:0] fld, input logic [1:0] src,
		input logic [3:0] np, input logic [6:0] hp, input int exp);
		@(posedge pclk);
		ch3_channel_enable <= 1'b0;
		ch4_channel_enable <= 1'b0;
		// Direction may only change while both channels are off
		apb(1'b1, MODE, ch ? {16'h0, fld, 8'h00} : {24'h0, fld});
		@(posedge pclk);
		ch3_channel_enable <= !ch;
		ch4_channel_enable <= ch;
		pick   <= src;
		npulse <= np;
		half   <= hp;
		start  <= 1'b1;
		n3 = 0;
		n4 = 0;
		@(posedge pclk);
		start <= 1'b0;
		step(1);
		while (busy !== 1'b0)
			@(posedge pclk);
		step(200);
		`CHK("captures", exp, ch ? n4 : n3)
		`CHK("other captures", 0, ch ? n3 : n4)
		apb(1'b0, ch ? CH4_COMPARE_OFFSET : CH3_COMPARE_OFFSET, 32'h0);
		if (exp > 0)
			`CHK("captured value", {16'h0, counter_value}, rdat)
	endtask

	initial
	begin
		#200000;
		n_errors++;
		conclude();
	end

	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_force();
		t_match();
		t_pwm();
		t_fast();
		t_buffer();
		@(posedge pclk);
		counter_value <= 16'h0ABC;
		// Source 3 is the internal trigger, taken as already chosen upstream
		for (int s = 1; s < 4; s++)
		begin
			cap(1'b1, 8'(s), s == 3 ? 2'd2 : 2'(s == 1), 4'h4, 7'h03, 4);
			cap(1'b0, 8'(s), s == 3 ? 2'd2 : 2'(s == 2), 4'h4, 7'h03, 4);
		end
		for (int d = 0; d < 4; d++)
			cap(1'b1, {4'h0, 2'(d), 2'b01}, 2'd1, 4'hC, 7'h03, d == 3 ? 2 : 12 >> d);
		cap(1'b1, 8'h31, 2'd1, 4'h3, 7'd4, 0);
		cap(1'b1, 8'h31, 2'd1, 4'h3, 7'd12, 3);
		cap(1'b1, 8'hA1, 2'd1, 4'h3, 7'd40, 0);
		cap(1'b1, 8'hA1, 2'd1, 4'h3, 7'd100, 3);
		conclude();
	end
endmodule // tb_timer_ch34_mode_config
`default_nettype wire

// File: verif/timer_ch34_monitor.sv
// Concurrent checks on the channel 3/4 mode block ports
`default_nettype none
module timer_ch34_monitor
	import timer_ch34_pkg::*;
#(
	parameter logic [15:0] MODE_CFG_OFFSET = MODE_CFG_TIMER1_OFFSET
)
(
	input wire logic        pclk,                // clock
	input wire logic        presetn,             // reset
	input wire logic        psel,                // select
	input wire logic        penable,             // access
	input wire logic        pwrite,              // write
	input wire logic [15:0] paddr,               // address
	input wire logic [31:0] pwdata,              // write data
	input wire logic [31:0] prdata,              // read data
	input wire logic        ch3_polarity,        // ch3 polarity
	input wire logic        ch4_polarity,        // ch4 polarity
	input wire logic        ch4_channel_enable,  // ch4 enable
	input wire logic        ch3_reference_level, // ch3 ref
	input wire logic        ch4_reference_level, // ch4 ref
	input wire logic        ch3_compare_output,  // ch3 out
	input wire logic        ch4_compare_output,  // ch4 out
	input wire logic        ch4_capture_event    // ch4 capture
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] cfg;
	wire         cfg_hit = psel && penable && paddr == MODE_CFG_OFFSET;
	wire  [2:0]  mode4   = cfg[14:12];
	wire         out4    = cfg[9:8] == 2'b00;

	// Shadow of the mode register so the ref checks know the programmed mode
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			cfg <= 16'h0000;
		else if (cfg_hit && pwrite)
			cfg <= pwdata[15:0];

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_force_inactive: assert property ($past(out4) && $past(mode4) == 3'h4 |-> !ch4_reference_level)
		else $error("ref not low in force-inactive mode");
	a_force_active: assert property ($past(out4) && $past(mode4) == 3'h5 |-> ch4_reference_level)
		else $error("ref not high in force-active mode");
	a_frozen_hold: assert property ($past(out4) && $past(mode4) == 3'h0 |-> $stable(ch4_reference_level))
		else $error("ref moved in frozen mode");
	a_input_ref_low: assert property ($past(!out4) |-> !ch4_reference_level)
		else $error("ref active on an input channel");
	a_capture_gate: assert property (ch4_capture_event |-> $past(!out4 && ch4_channel_enable))
		else $error("capture on an output or disabled channel");
	// Guarded by the previous reset level: outputs are cleared, not derived, during reset
	a_out_polarity4: assert property ($past(presetn) |->
		ch4_compare_output == (ch4_reference_level ^ $past(ch4_polarity)))
		else $error("ch4 output not ref through polarity");
	a_out_polarity3: assert property ($past(presetn) |->
		ch3_compare_output == (ch3_reference_level ^ $past(ch3_polarity)))
		else $error("ch3 output not ref through polarity");
	a_mode_readback: assert property (cfg_hit && !pwrite |-> prdata == {16'h0000, cfg})
		else $error("mode register read differs from written value");
endmodule // timer_ch34_monitor

bind timer_ch34_mode_config timer_ch34_monitor #(.MODE_CFG_OFFSET(MODE_CFG_OFFSET)) timer_ch34_monitor_inst (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .ch3_polarity, .ch4_polarity,
	.ch4_channel_enable, .ch3_reference_level, .ch4_reference_level, .ch3_compare_output,
	.ch4_compare_output, .ch4_capture_event
);
`default_nettype wire

// File: verif/timer_pin_model.sv
// Pin-side model: drives the timer input pins with counted pulse trains
`default_nettype none
module timer_pin_model
(
	input  wire logic       pclk,                   // clock
	input  wire logic       presetn,                // reset
	input  wire logic       start,                  // begin a train
	input  wire logic [1:0] pick,                   // 0 pin three, 1 pin four, 2 trigger
	input  wire logic [3:0] npulse,                 // pulses in train
	input  wire logic [6:0] half,                   // half period
	output logic            timer_input_three,      // pin three
	output logic            timer_input_four,       // pin four
	output logic            internal_trigger_input, // trigger
	output logic            busy                    // train running
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [6:0] t;
	logic [4:0] left;
	logic       lvl;

	// Unselected sources sit low so they never show an edge
	assign timer_input_three      = lvl && pick == 2'd0;
	assign timer_input_four       = lvl && pick == 2'd1;
	assign internal_trigger_input = lvl && pick == 2'd2;
	assign busy                   = left != 5'd0;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			t    <= 7'd0;
			left <= 5'd0;
			lvl  <= 1'b0;
		end
		else if (start)
		begin
			t    <= half;
			left <= {npulse, 1'b0};
		end
		else if (busy && t > 7'd1)
			t <= t - 7'd1;
		else if (busy)
		begin
			t    <= half;
			lvl  <= !lvl;
			left <= left - 5'd1;
		end
endmodule // timer_pin_model
`default_nettype wire

// File: verilog/timer_ch34_mode_config.sv
// Capture/compare channels 3 and 4: output reference, input filter, capture and APB registers
//
// The APB register port is this design's own decision.
`default_nettype none

// Functional notes
// - Mode 000 ignores matches; 001 sets, 010 clears, 011 toggles reference on match.
// - Mode 100 forces reference inactive; mode 101 forces it active.
// - PWM1: up counting active below compare; down counting inactive above compare.
// - PWM2: up counting inactive below compare; down counting active above compare.
// - PWM reference changes only on comparison change, frozen-to-PWM switch or fast trigger.
// - Buffer off: compare writes reach the active register immediately, except in a cycle where a capture lands.
// - Buffer on: accesses hit the buffer, copied to active on update event.
// - Fast off: output follows counter and compare only, trigger latency five cycles.
// - Fast on: trigger edge acts as match, output at compare level after three cycles.
// - Fast enable acts only in the two PWM modes.
// - Filter passes a new level after N equal consecutive samples.
// - Filter code selects sampling divider and sample count N per table.
// - Capture divider codes capture every 1, 2, 4 or 6 edges.
// - Channel 4 select: output, input four, input three, internal trigger.
// - Channel 3 select: output, input three, input four, internal trigger.
// - Output fields apply only when select is zero; input fields otherwise.
// - Channel 4 fields sit in bits 15:8, channel 3 in bits 7:0.
// - Mode register resets to zero: outputs, frozen, buffer and fast off.
// - Reference is active high; output level applies the channel polarity.
module timer_ch34_mode_config
	import timer_ch34_pkg::*;
#(
	parameter logic [15:0] MODE_CFG_OFFSET = MODE_CFG_TIMER1_OFFSET
)
(
	input  wire logic        pclk,                   // Timer and bus clock
	input  wire logic        presetn,                // Async reset, active low
	input  wire logic        psel,                   // APB select
	input  wire logic        penable,                // APB access phase
	input  wire logic        pwrite,                 // APB write
	input  wire logic [15:0] paddr,                  // APB byte address
	input  wire logic [31:0] pwdata,                 // APB write data
	output logic      [31:0] prdata,                 // APB read data
	output logic             pready,                 // APB ready
	output logic             pslverr,                // APB error on unmapped address
	input  wire logic [15:0] counter_value,          // Timer counter
	input  wire logic        count_down,             // Counter direction, 1 = down
	input  wire logic        update_event,           // Update event pulse
	input  wire logic        trigger_edge,           // Active trigger edge pulse
	input  wire logic        timer_input_three,      // Input pin 3 level
	input  wire logic        timer_input_four,       // Input pin 4 level
	input  wire logic        internal_trigger_input, // Internal trigger level
	input  wire logic        ch3_polarity,           // Channel 3 polarity
	input  wire logic        ch4_polarity,           // Channel 4 polarity
	input  wire logic        ch3_channel_enable,     // Channel 3 enable
	input  wire logic        ch4_channel_enable,     // Channel 4 enable
	output logic             ch3_reference_level,    // Channel 3 reference
	output logic             ch4_reference_level,    // Channel 4 reference
	output logic             ch3_compare_output,     // Channel 3 output level
	output logic             ch4_compare_output,     // Channel 4 output level
	output logic             ch3_capture_event,      // Channel 3 capture pulse
	output logic             ch4_capture_event       // Channel 4 capture pulse
);

	logic [15:0]                 mode_reg;
	logic [4:0]                  div_cnt;
	logic [FAST_PIPE_STAGES-1:0] trig_pipe;
	logic [1:0]                  ref_level;
	logic [1:0]                  out_level;
	logic [1:0]                  cap_pulse;
	logic [1:0]                  flt_level;
	logic [1:0]                  chan_is_input;
	logic [15:0]                 cmp_read [2];
	logic [1:0]                  in_pin;
	logic [1:0]                  pol;
	logic [1:0]                  chan_en;
	logic [1:0]                  wr_cmp;

	wire        access     = psel & penable;
	wire        setup      = psel & ~penable;
	wire        wr_access  = access & pwrite;
	wire        hit_mode   = (paddr == MODE_CFG_OFFSET);
	wire        hit_cmp3   = (paddr == CH3_COMPARE_OFFSET);
	wire        hit_cmp4   = (paddr == CH4_COMPARE_OFFSET);
	wire        hit_status = (paddr == STATUS_OFFSET);
	wire        mapped     = hit_mode | hit_cmp3 | hit_cmp4 | hit_status;
	wire        wr_mode    = wr_access & hit_mode;
	wire [31:0] status_word = {26'h0, chan_is_input, flt_level, ref_level};
	wire [31:0] rd_value   = hit_mode ? {16'h0000, mode_reg} :
	                         hit_cmp3 ? {16'h0000, cmp_read[0]} :
	                         hit_cmp4 ? {16'h0000, cmp_read[1]} :
	                         hit_status ? status_word : READ_ZERO;

	assign wr_cmp  = {wr_access & hit_cmp4, wr_access & hit_cmp3};
	assign in_pin  = {timer_input_four, timer_input_three};
	assign pol     = {ch4_polarity, ch3_polarity};
	assign chan_en = {ch4_channel_enable, ch3_channel_enable};

	// One wait-free access: read data is latched during setup
	assign pready  = 1'b1;
	assign pslverr = access & ~mapped;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= READ_ZERO;
		else if (setup)
			prdata <= rd_value;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mode_reg <= MODE_CFG_RESET;
		else if (wr_mode)
			mode_reg <= pwdata[15:0];
	end

	// Shared sampling divider for the input filters
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_cnt <= 5'h00;
		else
			div_cnt <= div_cnt + 5'h01;
	end

	// Trigger edge pipeline; the ref flop adds the last stage
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			trig_pipe <= '0;
		else
			trig_pipe <= {trig_pipe[FAST_PIPE_STAGES-2:0], trigger_edge};
	end

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : chan
			chan_cfg_t       cfg;
			filter_setting_t fset;
			logic            is_output;
			logic            is_input;
			logic            buf_eff;
			logic            src_raw;
			logic            smp_tick;
			logic [4:0]      rate_mask;
			logic [3:0]      flt_cnt;
			logic            flt_q;
			logic            pol_q;
			logic            edge_rise;
			logic [2:0]      ev_cnt;
			logic            ev_last;
			logic            cap_now;
			logic            cap_q;
			logic [15:0]     cmp_active;
			logic [15:0]     cmp_buffer;
			logic            match;
			logic            match_q;
			logic            match_hit;
			logic            is_pwm;
			logic            below;
			logic            above;
			logic            pwm_raw;
			logic            pwm_q;
			output_mode_t    mode_q;
			logic            fast_hit;
			logic            ref_q;
			logic            out_q;
			logic            next_ref;

			assign cfg       = decode_chan(mode_reg[g*CHAN_FIELD_STRIDE +: CHAN_FIELD_STRIDE]);
			assign is_output = (cfg.dir == DIR_OUTPUT);
			assign is_input  = ~is_output;
			assign buf_eff   = is_output & cfg.buffer_en;
			assign fset      = filter_setting(cfg.filter);
			assign rate_mask = 5'((6'h01 << fset.rate_log2) - 6'h01);
			assign smp_tick  = ((div_cnt & rate_mask) == 5'h00);

			// Own pin for code 01, the other pin for 10, trigger for 11
			always_comb
			begin
				case (cfg.dir)
					DIR_OWN_INPUT:   src_raw = in_pin[g];
					DIR_OTHER_INPUT: src_raw = in_pin[1-g];
					DIR_TRIGGER:     src_raw = internal_trigger_input;
					default:         src_raw = 1'b0;
				endcase
			end

			// Level moves only after length equal samples in a row
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					flt_cnt <= 4'h0;
					flt_q   <= 1'b0;
				end
				else if (!is_input)
				begin
					flt_cnt <= 4'h0;
					flt_q   <= 1'b0;
				end
				else if (smp_tick)
				begin
					if (src_raw == flt_q)
						flt_cnt <= 4'h0;
					else if (flt_cnt + 4'h1 >= fset.length)
					begin
						flt_q   <= src_raw;
						flt_cnt <= 4'h0;
					end
					else
						flt_cnt <= flt_cnt + 4'h1;
				end
			end

			assign edge_rise = (flt_q ^ pol[g]) & ~pol_q;
			assign ev_last   = (ev_cnt + 3'h1 == capture_ratio(cfg.divider));
			assign cap_now   = edge_rise & ev_last & is_input & chan_en[g];

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					pol_q  <= 1'b0;
					ev_cnt <= 3'h0;
					cap_q  <= 1'b0;
				end
				else
				begin
					pol_q <= flt_q ^ pol[g];
					cap_q <= cap_now;
					if (!(is_input && chan_en[g]))
						ev_cnt <= 3'h0;
					else if (edge_rise)
						ev_cnt <= ev_last ? 3'h0 : ev_cnt + 3'h1;
				end
			end

			// Buffer and active copy; a capture lands in both
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					cmp_active <= COMPARE_RESET;
					cmp_buffer <= COMPARE_RESET;
				end
				else if (cap_now)
				begin
					cmp_active <= counter_value;
					cmp_buffer <= counter_value;
				end
				else
				begin
					if (wr_cmp[g])
						cmp_buffer <= pwdata[15:0];
					if (wr_cmp[g] && !buf_eff)
						cmp_active <= pwdata[15:0];
					else if (update_event && buf_eff)
						cmp_active <= cmp_buffer;
				end
			end

			assign cmp_read[g] = is_output ? cmp_buffer : cmp_active;

			assign match     = (counter_value == cmp_active);
			assign match_hit = match & ~match_q;
			assign below     = (counter_value < cmp_active);
			assign above     = (counter_value > cmp_active);
			assign is_pwm    = (cfg.mode == OM_PWM1) | (cfg.mode == OM_PWM2);
			assign fast_hit  = trig_pipe[FAST_PIPE_STAGES-1] & cfg.fast_en & is_pwm;

			always_comb
			begin
				if (cfg.mode == OM_PWM1)
					pwm_raw = count_down ? ~above : below;
				else
					pwm_raw = count_down ? above : ~below;
			end

			// Without fast enable the trigger never reaches this path
			always_comb
			begin
				next_ref = ref_q;
				if (!is_output)
					next_ref = 1'b0;
				else
				begin
					case (cfg.mode)
						OM_FROZEN:         next_ref = ref_q;
						OM_SET_ON_MATCH:   next_ref = match_hit | ref_q;
						OM_CLEAR_ON_MATCH: next_ref = ~match_hit & ref_q;
						OM_TOGGLE:         next_ref = match_hit ^ ref_q;
						OM_FORCE_LOW:      next_ref = 1'b0;
						OM_FORCE_HIGH:     next_ref = 1'b1;
						OM_PWM1, OM_PWM2:
						begin
							if (fast_hit)
								next_ref = 1'b1;
							else if (pwm_raw != pwm_q || mode_q == OM_FROZEN)
								next_ref = pwm_raw;
						end
						default:           next_ref = ref_q;
					endcase
				end
			end

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					match_q <= 1'b0;
					pwm_q   <= 1'b0;
					mode_q  <= OM_FROZEN;
					ref_q   <= 1'b0;
					out_q   <= 1'b0;
				end
				else
				begin
					match_q <= match;
					pwm_q   <= pwm_raw;
					mode_q  <= cfg.mode;
					ref_q   <= next_ref;
					out_q   <= next_ref ^ pol[g];
				end
			end

			assign ref_level[g]     = ref_q;
			assign out_level[g]     = out_q;
			assign cap_pulse[g]     = cap_q;
			assign flt_level[g]     = flt_q;
			assign chan_is_input[g] = is_input;
		end
	endgenerate

	assign ch3_reference_level = ref_level[0];
	assign ch4_reference_level = ref_level[1];
	assign ch3_compare_output  = out_level[0];
	assign ch4_compare_output  = out_level[1];
	assign ch3_capture_event   = cap_pulse[0];
	assign ch4_capture_event   = cap_pulse[1];

endmodule // timer_ch34_mode_config

`default_nettype wire

// File: verilog/timer_ch34_pkg.sv
// Constants, types and field decoders for the channel 3/4 mode block
`default_nettype none

package timer_ch34_pkg;

	localparam logic [15:0] MODE_CFG_TIMER1_OFFSET = 16'hE01C;
	localparam logic [15:0] MODE_CFG_TIMER2_OFFSET = 16'hF01C;
	localparam logic [15:0] CH3_COMPARE_OFFSET     = 16'hE03C;
	localparam logic [15:0] CH4_COMPARE_OFFSET     = 16'hE040;
	localparam logic [15:0] STATUS_OFFSET          = 16'hE044;
	localparam logic [15:0] MODE_CFG_RESET         = 16'h0000;
	localparam logic [15:0] COMPARE_RESET          = 16'h0000;
	localparam logic [31:0] READ_ZERO              = 32'h0000_0000;

	localparam int CHAN_FIELD_STRIDE = 8;
	localparam int SEL_LSB           = 0;
	localparam int FAST_BIT          = 2;
	localparam int DIVIDER_LSB       = 2;
	localparam int BUFFER_BIT        = 3;
	localparam int MODE_LSB          = 4;
	localparam int FILTER_LSB        = 4;

	localparam int NORMAL_TRIGGER_MIN_CYCLES = 5;
	localparam int FAST_TRIGGER_CYCLES       = 3;
	localparam int FAST_PIPE_STAGES          = FAST_TRIGGER_CYCLES - 1;

	typedef enum logic [2:0] {
		OM_FROZEN, OM_SET_ON_MATCH, OM_CLEAR_ON_MATCH, OM_TOGGLE,
		OM_FORCE_LOW, OM_FORCE_HIGH, OM_PWM1, OM_PWM2
	} output_mode_t;

	typedef enum logic [1:0] {
		DIR_OUTPUT, DIR_OWN_INPUT, DIR_OTHER_INPUT, DIR_TRIGGER
	} direction_t;

	typedef struct packed {
		output_mode_t mode;
		logic         buffer_en;
		logic         fast_en;
		logic [3:0]   filter;
		logic [1:0]   divider;
		direction_t   dir;
	} chan_cfg_t;

	typedef struct packed {
		logic [2:0] rate_log2;
		logic [3:0] length;
	} filter_setting_t;

	function automatic chan_cfg_t decode_chan(input logic [7:0] f);
		chan_cfg_t c;
		c.mode      = output_mode_t'(f[MODE_LSB +: 3]);
		c.buffer_en = f[BUFFER_BIT];
		c.fast_en   = f[FAST_BIT];
		c.filter    = f[FILTER_LSB +: 4];
		c.divider   = f[DIVIDER_LSB +: 2];
		c.dir       = direction_t'(f[SEL_LSB +: 2]);
		return c;
	endfunction

	function automatic filter_setting_t filter_setting(input logic [3:0] code);
		filter_setting_t s;
		case (code)
			4'h0: s = '{3'h0, 4'h1};
			4'h1: s = '{3'h0, 4'h2};
			4'h2: s = '{3'h0, 4'h4};
			4'h3: s = '{3'h0, 4'h8};
			4'h4: s = '{3'h1, 4'h6};
			4'h5: s = '{3'h1, 4'h8};
			4'h6: s = '{3'h2, 4'h6};
			4'h7: s = '{3'h2, 4'h8};
			4'h8: s = '{3'h3, 4'h6};
			4'h9: s = '{3'h3, 4'h8};
			4'hA: s = '{3'h4, 4'h5};
			4'hB: s = '{3'h4, 4'h6};
			4'hC: s = '{3'h4, 4'h8};
			4'hD: s = '{3'h5, 4'h5};
			4'hE: s = '{3'h5, 4'h6};
			default: s = '{3'h5, 4'h8};
		endcase
		return s;
	endfunction

	function automatic logic [2:0] capture_ratio(input logic [1:0] code);
		case (code)
			2'h0: return 3'h1;
			2'h1: return 3'h2;
			2'h2: return 3'h4;
			default: return 3'h6;
		endcase
	endfunction

endpackage

`default_nettype wire
